// >>> core/pulse_sweep_sequencer.sv
/*
 * Pulse source and sweep sequencer with APB register access.
 * Assumes TRIGGER_IN, MEASURE_DONE and RANGE_BUSY are synchronous to CLOCK.
 */
// Decided for this implementation: the register addresses and the APB slave port.
// Notes on behaviour
// [R1] Free-running pulse: one cycle per period
// [R2] Overrun: keep width, stretch cycle, flag
// [R3] Level change while pulsing restarts cycle
// [R4] Per-trigger: measure after delay from trigger
// [R5] Per-trigger: triggers inside period ignored
// [R6] Trigger during range switch held, then run
// [R7] Wait operate time before first pulse
// [R8] Base and pulse share one range
// [R9] No measurement in standby or suspend
// [R10] Fixed sweep, DC and pulsed forms
// [R11] Random sweep from memory, start to stop
// [R12] Linear and two-slope staircase sweeps
// [R13] Over 8000 steps raises error 801
// [R14] Sweep settings locked while sweeping
// [R15] Indicator: rotating, steady, off
// [R16] Bias level output before sweep
// [R17] Start trigger switches to start level
// [R18] Stepping begins after hold time
// [R19] Free-running step waits for measurement
// [R20] Per-trigger: one step per trigger
// [R21] Hold time only on first pass
// [R22] Count passes, stop after final one
`timescale 1ns/1ps

module pulse_sweep_sequencer
    import sequencer_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // External control
    input  wire logic        TRIGGER_IN,
    output logic             SYNC_OUT,
    output logic             COMPLETE_OUT,
    // Measure and range circuitry
    input  wire logic        MEASURE_DONE,
    input  wire logic        RANGE_BUSY,
    output logic             MEASURE_START,
    output logic             RANGE_SEL,
    // Source and status
    output logic      [15:0] SOURCE_LEVEL,
    output logic             PULSE_ON,
    output logic             PERIOD_OVERRUN,
    output logic      [1:0]  SWEEP_IND
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_OPWAIT,
        ST_BIAS,
        ST_HOLDT,
        ST_ARM,
        ST_CYCLE,
        ST_DONE
    } state_type;

    state_type          state;
    logic        [5:0]  tick_cnt;
    logic        [23:0] timer;
    logic               operate, suspend, per_trigger, sweep_en, pulsed, return_to_bias_option;
    logic               soft_start;
    sweep_kind_type     kind;
    logic        [23:0] cycle_period, pulse_width, measure_delay, sweep_hold_time, opwait;
    levels_type         levels;
    start_type          start;
    steps_type          steps;
    logic signed [15:0] middle;
    logic        [15:0] count, repeat_count;
    logic        [7:0]  addr_first, addr_last, mem_addr;
    logic signed [15:0] mem [0:255];
    logic signed [15:0] sweep_level;
    logic        [7:0]  mem_ptr;
    logic        [15:0] steps_done, passes_done;
    logic               meas_issued, measuring, pending;
    logic        [11:0] err_code;

    // ****************************************
    // Decode
    // ****************************************
    wire tick       = (tick_cnt == TICK_LAST);
    wire access     = PSEL & PENABLE & PREADY;
    wire wr         = access & PWRITE;
    wire standby    = ~operate | suspend;
    wire sweep_idle = (state == ST_BIAS) | (state == ST_DONE);
    wire cfg_ok     = standby;
    wire time_ok    = standby | sweep_idle;
    wire wr_ctrl    = wr & (PADDR == OFS_CTRL);
    wire wr_levels  = wr & (PADDR == OFS_LEVELS);
    wire wr_status  = wr & (PADDR == OFS_STATUS);
    wire wr_mem     = wr & (PADDR == OFS_MEM_DATA) & cfg_ok;
    wire mapped     = (PADDR[1:0] == 2'b00) & (PADDR <= OFS_MEM_DATA);

    wire [15:0] total = (kind == SW_RANDOM) ? 16'(addr_last - addr_first) + 16'h0001 : count;
    wire        too_many   = sweep_en & (total > MAX_STEPS);
    wire        last_step  = (steps_done == total - 16'h0001);
    wire        last_pass  = (passes_done + 16'h0001 >= repeat_count);

    wire signed [15:0] lvl_now  = (kind == SW_RANDOM) ? mem[mem_ptr] : sweep_level;
    wire signed [15:0] src      = sweep_en ? lvl_now : levels.pulse;
    wire               past_mid = (steps.first >= 0) ? (sweep_level >= middle) : (sweep_level <= middle);
    wire signed [15:0] step_now = ((kind == SW_TWO_SLOPE) && past_mid) ? steps.second : steps.first;
    wire signed [15:0] next_sweep_level = (kind == SW_FIXED) ? sweep_level : sweep_level + step_now;

    wire pulse_now  = pulsed & (timer < pulse_width);
    wire trig_go    = per_trigger ? (TRIGGER_IN | pending) : 1'b1;
    wire arm_go     = trig_go & ~RANGE_BUSY;
    wire run_start  = TRIGGER_IN | soft_start;
    wire period_up  = timer >= cycle_period;
    wire cycle_end  = period_up & meas_issued & ~measuring & ~MEASURE_DONE;
    wire restart    = wr_levels & (state == ST_CYCLE) & ~sweep_en;

    function automatic logic [15:0] magnitude(input logic signed [15:0] v);
        magnitude = v[15] ? 16'(-v) : 16'(v);
    endfunction

    wire next_range = (magnitude(levels.base) >= RANGE_LIMIT) | (magnitude(src) >= RANGE_LIMIT);

    wire [15:0] next_level =
        (state == ST_BIAS)  ? start.bias :
        (state == ST_DONE)  ? (return_to_bias_option ? start.bias : lvl_now) :
        (state == ST_HOLDT) ? lvl_now :
        (state == ST_CYCLE) ? (pulsed ? (pulse_now ? src : levels.base) : src) :
        (state == ST_ARM)   ? (pulsed ? levels.base : src) :
        16'h0000;

    wire [1:0] next_ind =
        ((state == ST_HOLDT) | (state == ST_CYCLE) | ((state == ST_ARM) & ~per_trigger)) ? 2'd2 :
        ((state == ST_BIAS) | (state == ST_ARM)) ? 2'd1 : 2'd0;

    wire [31:0] next_prdata =
        (PADDR == OFS_CTRL)     ? {24'h00_0000, 1'b0, kind, pulsed, sweep_en, per_trigger, suspend, operate} :
        (PADDR == OFS_PERIOD)   ? {8'h00, cycle_period} :
        (PADDR == OFS_WIDTH)    ? {8'h00, pulse_width} :
        (PADDR == OFS_MDELAY)   ? {8'h00, measure_delay} :
        (PADDR == OFS_HOLD)     ? {8'h00, sweep_hold_time} :
        (PADDR == OFS_OPWAIT)   ? {8'h00, opwait} :
        (PADDR == OFS_LEVELS)   ? levels :
        (PADDR == OFS_START)    ? start :
        (PADDR == OFS_STEPS)    ? steps :
        (PADDR == OFS_COUNT)    ? {middle, count} :
        (PADDR == OFS_FUNC)     ? {15'h0000, return_to_bias_option, repeat_count} :
        (PADDR == OFS_ADDR)     ? {16'h0000, addr_last, addr_first} :
        (PADDR == OFS_STATUS)   ? {13'h0000, state, err_code, 1'b0, SWEEP_IND, PERIOD_OVERRUN} :
        (PADDR == OFS_MEM_ADDR) ? {24'h00_0000, mem_addr} :
        32'h0000_0000;

    // ****************************************
    // APB slave and time base
    // ****************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY   <= 1'b0;
            PRDATA   <= 32'h0000_0000;
            PSLVERR  <= 1'b0;
            tick_cnt <= 6'h00;
        end else begin
            PREADY   <= PSEL & ~PENABLE;
            PRDATA   <= next_prdata;
            PSLVERR  <= PSEL & ~PENABLE & ~mapped;
            tick_cnt <= tick ? 6'h00 : tick_cnt + 6'h01;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            operate         <= 1'b0;
            suspend         <= 1'b0;
            per_trigger     <= 1'b0;
            sweep_en        <= 1'b0;
            pulsed          <= 1'b0;
            kind            <= SW_LINEAR;
            soft_start      <= 1'b0;
            cycle_period    <= RST_PERIOD;
            pulse_width     <= RST_WIDTH;
            measure_delay   <= RST_MDELAY;
            sweep_hold_time <= RST_HOLD;
            opwait          <= RST_OPWAIT;
            levels          <= '0;
            start           <= '0;
            steps           <= '0;
            middle          <= '0;
            count           <= RST_COUNT;
            repeat_count    <= RST_REPEAT;
            return_to_bias_option             <= 1'b0;
            addr_first      <= 8'h00;
            addr_last       <= 8'h00;
            mem_addr        <= 8'h00;
        end else begin
            soft_start <= wr_ctrl & PWDATA[CTRL_START];
            if (wr_ctrl) begin
                operate     <= PWDATA[CTRL_OPERATE];
                suspend     <= PWDATA[CTRL_SUSPEND];
                per_trigger <= PWDATA[CTRL_PER_TRIG];
                if (cfg_ok) begin // [R14]
                    sweep_en <= PWDATA[CTRL_SWEEP];
                    pulsed   <= PWDATA[CTRL_PULSED]; // [R10]
                    kind     <= sweep_kind_type'(PWDATA[CTRL_KIND_LO +: 2]);
                end
            end
            if (wr && time_ok) begin // [R14]
                if (PADDR == OFS_PERIOD) cycle_period <= PWDATA[23:0];
                if (PADDR == OFS_WIDTH)  pulse_width <= PWDATA[23:0];
                if (PADDR == OFS_MDELAY) measure_delay <= PWDATA[23:0];
                if (PADDR == OFS_HOLD)   sweep_hold_time <= PWDATA[23:0];
                if (PADDR == OFS_ADDR) begin
                    addr_first <= PWDATA[7:0];
                    addr_last  <= PWDATA[15:8];
                end
                if (PADDR == OFS_FUNC) begin
                    repeat_count <= PWDATA[15:0];
                    return_to_bias_option          <= PWDATA[FUNC_RTB];
                end
            end
            if (wr && cfg_ok) begin // [R14]
                if (PADDR == OFS_OPWAIT)   opwait <= PWDATA[23:0];
                if (PADDR == OFS_START)    start <= PWDATA;
                if (PADDR == OFS_STEPS)    steps <= PWDATA;
                if (PADDR == OFS_MEM_ADDR) mem_addr <= PWDATA[7:0];
                if (PADDR == OFS_COUNT) begin
                    count  <= PWDATA[15:0];
                    middle <= PWDATA[31:16];
                end
            end
            if (wr_levels && (cfg_ok || !sweep_en)) begin
                levels <= PWDATA;
            end
            if (wr_mem) begin
                mem_addr <= mem_addr + 8'h01;
            end
        end
    end

    // Value memory for random sweeps
    always_ff @(posedge CLOCK) begin
        if (wr_mem) begin
            mem[mem_addr] <= PWDATA[15:0]; // [R11]
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state          <= ST_STANDBY;
            timer          <= 24'h00_0000;
            sweep_level    <= 16'h0000;
            mem_ptr        <= 8'h00;
            steps_done     <= 16'h0000;
            passes_done    <= 16'h0000;
            meas_issued    <= 1'b0;
            measuring      <= 1'b0;
            pending        <= 1'b0;
            err_code       <= 12'h000;
            MEASURE_START  <= 1'b0;
            SYNC_OUT       <= 1'b0;
            COMPLETE_OUT   <= 1'b0;
            PERIOD_OVERRUN <= 1'b0;
        end else begin
            MEASURE_START <= 1'b0;
            SYNC_OUT      <= 1'b0;
            COMPLETE_OUT  <= 1'b0;
            if (tick) begin
                timer <= timer + 24'h00_0001;
            end
            if (measuring && MEASURE_DONE) begin
                measuring    <= 1'b0;
                COMPLETE_OUT <= 1'b1;
            end
            if (wr_status && PWDATA[STAT_OVERRUN]) begin
                PERIOD_OVERRUN <= 1'b0;
            end
            if (state == ST_CYCLE && period_up && measuring) begin
                PERIOD_OVERRUN <= 1'b1; // [R2]
            end
            if (standby) begin
                state     <= ST_STANDBY; // [R9]
                measuring <= 1'b0;
                pending   <= 1'b0;
                err_code  <= operate ? err_code : 12'h000;
            end else begin
                case (state)
                    ST_STANDBY: begin
                        if (too_many) begin
                            err_code <= ERR_OVER; // [R13]
                        end else begin
                            state <= ST_OPWAIT;
                            timer <= 24'h00_0000;
                        end
                    end
                    ST_OPWAIT: begin
                        if (timer >= opwait) begin                                      // [R7]
                            state <= sweep_en ? ST_BIAS : ST_ARM;
                        end
                    end
                    ST_BIAS, ST_DONE: begin
                        if (sweep_en && run_start) begin
                            state       <= ST_HOLDT;                                    // [R17]
                            timer       <= 24'h00_0000;
                            sweep_level <= start.first;
                            mem_ptr     <= addr_first;                                  // [R11]
                            steps_done  <= 16'h0000;
                            passes_done <= 16'h0000;
                        end
                    end
                    ST_HOLDT: begin
                        if (timer >= sweep_hold_time) begin                             // [R18]
                            state <= ST_ARM;
                        end
                    end
                    ST_ARM: begin
                        if (per_trigger && TRIGGER_IN && RANGE_BUSY) begin
                            pending <= 1'b1;                                            // [R6]
                        end
                        if (arm_go) begin                                               // [R20]
                            state       <= ST_CYCLE;
                            timer       <= 24'h00_0000;
                            meas_issued <= 1'b0;
                            pending     <= 1'b0;
                            SYNC_OUT    <= 1'b1;
                        end
                    end
                    ST_CYCLE: begin
                        if (!meas_issued && timer >= measure_delay) begin               // [R4]
                            MEASURE_START <= 1'b1;
                            meas_issued   <= 1'b1;
                            measuring     <= 1'b1;
                        end
                        if (restart) begin
                            state     <= ST_ARM;                                        // [R3]
                            measuring <= 1'b0;
                        end else if (cycle_end) begin                                   // [R1] [R5] [R19]
                            state <= ST_ARM;
                            if (sweep_en) begin
                                if (!last_step) begin
                                    steps_done  <= steps_done + 16'h0001;
                                    sweep_level <= next_sweep_level;                    // [R12]
                                    mem_ptr     <= mem_ptr + 8'h01;
                                end else if (last_pass) begin
                                    state <= ST_DONE;                                   // [R22]
                                end else begin
                                    passes_done <= passes_done + 16'h0001;              // [R21]
                                    steps_done  <= 16'h0000;
                                    sweep_level <= start.first;
                                    mem_ptr     <= addr_first;
                                end
                            end
                        end
                    end
                    default: state <= ST_STANDBY;
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            SOURCE_LEVEL <= 16'h0000;
            PULSE_ON     <= 1'b0;
            RANGE_SEL    <= 1'b0;
            SWEEP_IND    <= 2'd0;
        end else begin
            SOURCE_LEVEL <= next_level;                                                 // [R16]
            PULSE_ON     <= (state == ST_CYCLE) & pulse_now;
            RANGE_SEL    <= next_range;                                                 // [R8]
            SWEEP_IND    <= next_ind;                                                   // [R15]
        end
    end

endmodule

// >>> shared/sequencer_pkg.sv
/*
 * Constants and types for the pulse and sweep sequencer.
 * Assumes a 40 MHz system clock and a 1 us internal time base.
 */
package sequencer_pkg;

    // ****************************************
    // Time base
    // ****************************************
    localparam int         CLOCK_NS    = 25;
    localparam int         TICK_NS     = 1000;
    localparam int         TICK_CYCLES = (TICK_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam logic [5:0] TICK_LAST   = 6'(TICK_CYCLES - 1);

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PERIOD   = 8'h04;
    localparam logic [7:0] OFS_WIDTH    = 8'h08;
    localparam logic [7:0] OFS_MDELAY   = 8'h0C;
    localparam logic [7:0] OFS_HOLD     = 8'h10;
    localparam logic [7:0] OFS_OPWAIT   = 8'h14;
    localparam logic [7:0] OFS_LEVELS   = 8'h18;
    localparam logic [7:0] OFS_START    = 8'h1C;
    localparam logic [7:0] OFS_STEPS    = 8'h20;
    localparam logic [7:0] OFS_COUNT    = 8'h24;
    localparam logic [7:0] OFS_FUNC     = 8'h28;
    localparam logic [7:0] OFS_ADDR     = 8'h2C;
    localparam logic [7:0] OFS_STATUS   = 8'h30;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h34;
    localparam logic [7:0] OFS_MEM_DATA = 8'h38;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int CTRL_OPERATE  = 0;
    localparam int CTRL_SUSPEND  = 1;
    localparam int CTRL_PER_TRIG = 2;
    localparam int CTRL_SWEEP    = 3;
    localparam int CTRL_PULSED   = 4;
    localparam int CTRL_KIND_LO  = 5;
    localparam int CTRL_START    = 8;
    localparam int FUNC_RTB      = 16;
    localparam int STAT_OVERRUN  = 0;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [23:0] RST_PERIOD  = 24'h00_2710;
    localparam logic [23:0] RST_WIDTH   = 24'h00_03E8;
    localparam logic [23:0] RST_MDELAY  = 24'h00_01F4;
    localparam logic [23:0] RST_HOLD    = 24'h00_0000;
    localparam logic [23:0] RST_OPWAIT  = 24'h00_0064;
    localparam logic [15:0] RST_COUNT   = 16'h000A;
    localparam logic [15:0] RST_REPEAT  = 16'h0001;
    localparam logic [15:0] MAX_STEPS   = 16'h1F40;
    localparam logic [11:0] ERR_OVER    = 12'h321;
    localparam logic [15:0] RANGE_LIMIT = 16'h4000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SW_LINEAR,
        SW_FIXED,
        SW_RANDOM,
        SW_TWO_SLOPE
    } sweep_kind_type;

    typedef struct packed {
        logic signed [15:0] pulse;
        logic signed [15:0] base;
    } levels_type;

    typedef struct packed {
        logic signed [15:0] bias;
        logic signed [15:0] first;
    } start_type;

    typedef struct packed {
        logic signed [15:0] second;
        logic signed [15:0] first;
    } steps_type;

endpackage

// >>> verif/measure_model.sv
/* Measure and range circuitry model.
   Assumes MEASURE_START is a one-cycle pulse and RANGE_SEL a level, both synchronous. */
`timescale 1ns/1ps
module measure_model (
    // Clock
    input wire logic CLOCK,
    // Sequencer side and testbench speed select
    input wire logic MEASURE_START,
    input wire logic RANGE_SEL,
    input wire logic slow,
    output logic     MEASURE_DONE,
    output logic     RANGE_BUSY
);
    int   meas_cnt = 0;
    int   rng_cnt  = 0;
    logic last_rng = 1'b0;
    initial MEASURE_DONE = 1'b0;
    assign RANGE_BUSY = rng_cnt != 0;
    // Measurement lasts 20 or 600 cycles
    always @(posedge CLOCK) begin
        MEASURE_DONE <= meas_cnt == 1;
        if (MEASURE_START === 1'b1) meas_cnt <= slow ? 600 : 20;
        else if (meas_cnt > 0) meas_cnt <= meas_cnt - 1;
        last_rng <= RANGE_SEL;
        if (RANGE_SEL !== last_rng) rng_cnt <= 8;
        else if (rng_cnt > 0) rng_cnt <= rng_cnt - 1;
    end
endmodule

// >>> verif/pulse_sweep_checker.sv
/* Port checker for pulse_sweep_sequencer.
   Assumes it is bound to the sequencer top and sees only its ports. */
`timescale 1ns/1ps
module pulse_sweep_checker (
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RSTN,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Sequence
    input wire logic        SYNC_OUT,
    input wire logic        COMPLETE_OUT,
    input wire logic        MEASURE_DONE,
    input wire logic        RANGE_BUSY,
    input wire logic        MEASURE_START,
    input wire logic        PERIOD_OVERRUN,
    input wire logic [1:0]  SWEEP_IND
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    wire clear_hit = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h30 && PWDATA[0];
    sequence xfer_s;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    apb_ready_a: assert property (xfer_s |-> PREADY) else $error("no ready in access");
    apb_err_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    ready_once_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
    sync_pulse_a: assert property (SYNC_OUT |=> !SYNC_OUT) else $error("sync too long");
    meas_pulse_a: assert property (MEASURE_START |=> !MEASURE_START) else $error("start too long");
    done_cause_a: assert property (COMPLETE_OUT |-> $past(MEASURE_DONE)) else $error("complete uncaused");
    range_wait_a: assert property (SYNC_OUT |-> !$past(RANGE_BUSY)) else $error("cycle in range switch");
    overrun_hold_a: assert property (PERIOD_OVERRUN && !clear_hit |=> PERIOD_OVERRUN)
        else $error("overrun flag lost");
    ind_legal_a: assert property (SWEEP_IND != 2'b11) else $error("bad indicator");
endmodule

bind pulse_sweep_sequencer pulse_sweep_checker u_chk (.*);

// >>> verif/tb_pulse_sweep_sequencer.sv
/* Directed testbench for pulse_sweep_sequencer over APB.
   Assumes the package, the measure model and the checker are compiled first. */
`timescale 1ns/1ps
module tb_pulse_sweep_sequencer;
    import sequencer_pkg::*;
    logic        CLOCK, RSTN, PSEL, PENABLE, PWRITE, TRIGGER_IN, slow, err, PREADY, PSLVERR;
    logic        SYNC_OUT, COMPLETE_OUT, MEASURE_DONE, RANGE_BUSY, MEASURE_START, RANGE_SEL;
    logic        PULSE_ON, PERIOD_OVERRUN;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, q;
    logic [15:0] SOURCE_LEVEL;
    logic [1:0]  SWEEP_IND;
    int          n_errors = 0, n_checks = 0, n, d, ns, nm;
    logic [7:0]  ofs [4] = '{OFS_PERIOD, OFS_MDELAY, OFS_OPWAIT, OFS_FUNC};
    logic [31:0] rv [4]  = '{32'(RST_PERIOD), 32'(RST_MDELAY), 32'(RST_OPWAIT), 32'(RST_REPEAT)};
    pulse_sweep_sequencer u_dut (.*);
    measure_model u_meas (.*);
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string nme, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nme, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] dat);
        int k;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= dat;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLOCK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
        if (k >= 20) chk("ready wait", 0, 1);
        if (k >= 20) conclude();
    endtask
    function automatic logic hit(int s);
        case (s)
            0: return SYNC_OUT === 1'b1;
            1: return MEASURE_START === 1'b1;
            2: return PERIOD_OVERRUN === 1'b1;
            default: return SWEEP_IND === 2'b00;
        endcase
    endfunction
    task automatic wt(int s, int lim);
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (!hit(s) && n < lim);
        if (!hit(s)) chk("wait", s, 32'hFFFF_FFFF);
        if (!hit(s)) conclude();
    endtask
    task automatic count(int len);
        repeat (len) begin
            @(posedge CLOCK);
            ns += int'(SYNC_OUT === 1'b1);
            nm += int'(MEASURE_START === 1'b1);
        end
    endtask
    task automatic trig();
        TRIGGER_IN <= 1'b1;
        @(posedge CLOCK);
        TRIGGER_IN <= 1'b0;
    endtask
    initial begin
        {PSEL, PENABLE, PWRITE, TRIGGER_IN, slow, RSTN} = '0;
        {PADDR, PWDATA} = '0;
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
        @(posedge CLOCK);
        foreach (ofs[i]) begin
            apb(0, ofs[i], 0);
            chk("reset value", q, rv[i]);
        end
        apb(0, 8'h3C, 0);
        chk("unmapped", {q[30:0], err}, 32'h0000_0001);
        apb(1, OFS_PERIOD, 32'h0000_0008);
        apb(1, OFS_WIDTH, 32'h0000_0002);
        apb(1, OFS_MDELAY, 32'h0000_0001);
        apb(1, OFS_OPWAIT, 32'h0000_0002);
        apb(1, OFS_LEVELS, 32'h0100_0010);
        apb(1, OFS_CTRL, 32'h0000_0011);
        wt(0, 400);
        wt(1, 90);
        d = n;
        chk("measure delay", d inside {[1:85]}, 1);
        wt(0, 500);
        chk("period", (d + n) inside {[280:365]}, 1);
        repeat (20) @(posedge CLOCK);
        apb(1, OFS_LEVELS, 32'h4100_0010);
        wt(0, 100);
        chk("range", RANGE_SEL, 1);
        repeat (2) @(posedge CLOCK);
        chk("pulse level", {PULSE_ON, SOURCE_LEVEL}, 32'h0001_4100);
        slow <= 1'b1;
        wt(2, 1500);
        apb(0, OFS_STATUS, 0);
        chk("overrun", q[0], 1);
        slow <= 1'b0;
        wt(0, 1500);
        wt(0, 500);
        apb(1, OFS_STATUS, 32'h0000_0001);
        apb(0, OFS_STATUS, 0);
        chk("overrun clear", q[0], 0);
        apb(1, OFS_CTRL, 32'h0000_0015);
        repeat (1400) @(posedge CLOCK);
        {ns, nm} = '0;
        trig();
        count(40);
        trig();
        count(360);
        chk("one cycle per trigger", {ns[15:0], nm[15:0]}, 32'h0001_0001);
        apb(1, OFS_CTRL, 32'h0000_0017);
        {ns, nm} = '0;
        trig();
        count(400);
        chk("suspend measures", nm, 0);
        apb(1, OFS_CTRL, 32'h0000_0000);
        apb(1, OFS_COUNT, 32'h0000_1F41);
        apb(1, OFS_CTRL, 32'h0000_0009);
        apb(0, OFS_STATUS, 0);
        chk("step error", q[15:4], 32'(ERR_OVER));
        apb(1, OFS_CTRL, 32'h0000_0000);
        apb(1, OFS_COUNT, 32'h0000_0003);
        apb(1, OFS_START, 32'h0020_0040);
        apb(1, OFS_STEPS, 32'h0000_0010);
        apb(1, OFS_CTRL, 32'h0000_0009);
        repeat (150) @(posedge CLOCK);
        chk("bias", SOURCE_LEVEL, 32'h0000_0020);
        apb(1, OFS_CTRL, 32'h0000_0109);
        repeat (2) @(posedge CLOCK);
        chk("start level", SOURCE_LEVEL, 32'h0000_0040);
        wt(0, 100);
        chk("sweeping", SWEEP_IND, 2);
        {ns, nm} = '0;
        count(1200);
        chk("steps", ns, 2);
        chk("end level", {SWEEP_IND, SOURCE_LEVEL}, 32'h0000_0060);
        conclude();
    end
endmodule
